// *** pkg/cpm_cfg.svh ***
// Constants of the processor pin-control block: reset values, test-port codes, counts.
// Assumes inclusion by bare name from the core design file; the package does not include it.
`ifndef CPM_CFG_SVH
`define CPM_CFG_SVH

`define CPM_BUILTIN_SELF_TEST_CYCLES   16'h0040
`define CPM_BUS_IDLE      15'h5ff8
`define CPM_ASYNC_RST     5'h17
`define CPM_TAP_PIN_RST   3'h7
`define CPM_IR_IDCODE     4'h1
`define CPM_IR_BYPASS     4'hf
`define CPM_IR_CAPTURE    4'h1
`define CPM_DR_BYPASS_RST 32'h0000_0000

`endif

// *** pkg/cpm_pkg.sv ***
// Types of the processor pin-control block.
// Assumes cpm_cfg.svh is on the include path.
package cpm_pkg;

	typedef enum logic [2:0] {
		SQ_RESET = 3'h0,
		SQ_BUILTIN_SELF_TEST  = 3'h1,
		SQ_RUN   = 3'h3,
		SQ_TRI   = 3'h2,
		SQ_CHK   = 3'h6
	} cpm_seq_e;

	typedef enum logic [3:0] {
		TP_TLR    = 4'hf,
		TP_IDLE   = 4'hc,
		TP_SELDR  = 4'h7,
		TP_CAPDR  = 4'h6,
		TP_SHDR   = 4'h2,
		TP_EX1DR  = 4'h1,
		TP_PAUDR  = 4'h3,
		TP_EX2DR  = 4'h0,
		TP_UPDDR  = 4'h5,
		TP_SELIR  = 4'h4,
		TP_CAPIR  = 4'he,
		TP_SHIR   = 4'ha,
		TP_EX1IR  = 4'h9,
		TP_PAUIR  = 4'hb,
		TP_EX2IR  = 4'h8,
		TP_UPDIR  = 4'hd
	} cpm_tap_e;

	typedef enum logic {
		FILL_SHARED = 1'h0,
		FILL_EXCL   = 1'h1
	} cpm_fill_e;

	typedef struct packed {
		logic       write;
		logic       lock;
		logic       misaligned;
		logic       cache;
		logic       pcd;
		logic       pwt;
		logic [7:0] byte_en;
	} cpm_cyc_s;

	typedef struct packed {
		logic       address_strobe_n;
		logic       wr_not_rd;
		logic [7:0] byte_en_n;
		logic       cache_n;
		logic       lock_n;
		logic       pcd;
		logic       pwt;
		logic       split_cycle_flag;
	} cpm_bus_s;

endpackage

// *** hdl/cpm_sync.sv ***
// Two-flop synchroniser for a group of asynchronous pins.
// Assumes clk, synchronous active-low nrst and a clock enable.
`timescale 1ns/1ps
`default_nettype none
module cpm_sync #(
	parameter int         W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         clk,   // Core clock
	input  wire logic         nrst,  // Sync reset, active low
	input  wire logic         ce,    // Clock enable
	input  wire logic [W-1:0] din,   // Asynchronous pins
	output logic      [W-1:0] dout   // Synchronised copy
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;
	logic [W-1:0] nxt_meta;
	logic [W-1:0] nxt_sync;

	always_comb begin
		nxt_meta = ce ? din : meta_ff;
		nxt_sync = ce ? meta_ff : sync_ff;
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			meta_ff <= RST;
			sync_ff <= RST;
		end else begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
		end
	end

	assign dout = sync_ff;
endmodule
`default_nettype wire

// *** hdl/cpm_core.sv ***
// Pin control of the processor: reset and strap sampling, bus cycle definition pins,
// system management request, test access port and pin floating.
// Assumes bus requests come from core logic on clk; test pins arrive asynchronously.
`include "cpm_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module cpm_core #(
	parameter logic [15:0] BUILTIN_SELF_TEST_CYCLES = `CPM_BUILTIN_SELF_TEST_CYCLES,
	parameter logic [31:0] IDCODE_VAL  = 32'h0a5a_5001  // Arbitrary value
) (
	input  wire logic              clk,                        // Core clock, 40 MHz
	input  wire logic              nrst,                       // Sync reset, active low
	input  wire logic              ce,                         // Clock enable
	input  wire logic              reset_pin,                  // Device reset pin, high
	input  wire logic              init_pin,                   // Soft init strap, high
	input  wire logic              flush_n,                    // Cache flush strap, low
	input  wire logic              redundancy_check_mode_n,    // Checker strap, low
	input  wire logic              sys_mgmt_irq_n,             // Management request, low
	input  wire logic              hold,                       // Bus hold request
	input  wire logic              bus_backoff_n,              // Backoff, low
	input  wire logic              writeback_not_writethrough, // Fill line policy
	input  wire logic              tck,                        // Test clock pin
	input  wire logic              tms,                        // Test mode select
	input  wire logic              tdi,                        // Test data in
	input  wire logic              trst_n,                     // Test reset, low, async
	input  wire logic              cyc_valid,                  // Core bus cycle request
	input  wire cpm_pkg::cpm_cyc_s cyc_req,                    // Cycle attributes
	input  wire logic              instr_boundary,             // Instruction boundary
	input  wire logic              smm_exit,                   // Resume from mgmt mode
	input  wire logic              internal_fault,             // Internal error detected
	input  wire logic              fill_first_rdy,             // First ready of line fill
	output logic                   cyc_ready,                  // Cycle request taken
	output cpm_pkg::cpm_bus_s      bus_pins,                   // Cycle definition pins
	output logic                   bus_oe_n,                   // Bus pins enable, low
	output logic                   hlda,                       // Hold acknowledge
	output logic                   sys_mgmt_active_n,          // Mgmt mode active, low
	output logic                   misc_oe_n,                  // Status pins enable, low
	output logic                   internal_error_n,           // Internal error, low
	output logic                   tdo,                        // Test data out
	output logic                   tdo_oe_n,                   // TDO enable, low
	output logic                   restart_pulse,              // Execution restart
	output logic                   cache_inval_nowb,           // Invalidate, no write-back
	output logic                   builtin_self_test,          // Self test running
	output logic                   sys_mgmt_mode,              // In management mode
	output cpm_pkg::cpm_fill_e     fill_state,                 // Initial line state
	output logic                   fill_valid,                 // Fill state strobe
	output logic                   tristate_mode,              // Tristate test mode
	output logic                   checker_mode                // Checker mode
);
	logic [4:0] async_s;
	logic [2:0] tap_s;
	logic       reset_s, init_s, flush_s_n, frc_s_n, smi_s_n;
	logic       tck_s, tms_s, tdi_s;

	cpm_sync #(.W(5), .RST(`CPM_ASYNC_RST)) u_sync_async (
		.clk  (clk),
		.nrst (nrst),
		.ce   (ce),
		.din  ({reset_pin, init_pin, flush_n, redundancy_check_mode_n, sys_mgmt_irq_n}),
		.dout (async_s)
	);
	cpm_sync #(.W(3), .RST(`CPM_TAP_PIN_RST)) u_sync_tap (
		.clk  (clk),
		.nrst (nrst),
		.ce   (ce),
		.din  ({tck, tms, tdi}),
		.dout (tap_s)
	);
	assign {reset_s, init_s, flush_s_n, frc_s_n, smi_s_n} = async_s;
	assign {tck_s, tms_s, tdi_s} = tap_s;

	// Sequencer, bus and management state
	cpm_pkg::cpm_seq_e  seq_ff, nxt_seq;
	logic [15:0]        builtin_self_test_cnt_ff, nxt_builtin_self_test_cnt;
	logic               reset_d_ff, nxt_reset_d;
	logic               restart_ff, nxt_restart;
	logic               smi_d_ff, nxt_smi_d;
	logic               pend_ff, nxt_pend;
	logic               smm_ff, nxt_smm;
	cpm_pkg::cpm_bus_s  bus_ff, nxt_bus;
	logic               hlda_ff, nxt_hlda;
	logic               internal_error_n_ff, nxt_internal_error_n;
	cpm_pkg::cpm_fill_e fill_ff, nxt_fill;
	logic               fillv_ff, nxt_fillv;
	logic               reset_fall, smi_fall, smm_enter, float_all, float_bus;

	assign reset_fall = reset_d_ff & ~reset_s;
	assign smi_fall   = smi_d_ff & ~smi_s_n;
	assign float_all  = (seq_ff == cpm_pkg::SQ_TRI) | (seq_ff == cpm_pkg::SQ_CHK);
	assign float_bus  = float_all | hlda_ff | ~bus_backoff_n;
	assign smm_enter  = pend_ff & instr_boundary & ~smm_ff & (seq_ff == cpm_pkg::SQ_RUN);
	assign cyc_ready  = (seq_ff == cpm_pkg::SQ_RUN) & ~float_bus & ~hold;

	always_comb begin
		nxt_seq      = seq_ff;
		nxt_builtin_self_test_cnt = builtin_self_test_cnt_ff;
		nxt_restart  = 1'b0;
		nxt_reset_d  = reset_s;
		nxt_smi_d    = smi_s_n;
		nxt_bus      = bus_ff;
		nxt_bus.address_strobe_n = 1'b1;
		nxt_hlda     = hold & bus_ff.lock_n;
		nxt_internal_error_n     = internal_fault;
		nxt_fill     = fill_ff;
		nxt_fillv    = fill_first_rdy;
		nxt_pend     = smi_fall | (pend_ff & ~smm_enter);
		nxt_smm      = smm_enter | (smm_ff & ~smm_exit);
		case (seq_ff)
			cpm_pkg::SQ_RESET: begin
				if (reset_fall) begin
					if (!flush_s_n) begin
						nxt_seq = cpm_pkg::SQ_TRI;
					end else if (!frc_s_n) begin
						nxt_seq = cpm_pkg::SQ_CHK;
					end else if (init_s) begin
						nxt_seq      = cpm_pkg::SQ_BUILTIN_SELF_TEST;
						nxt_builtin_self_test_cnt = BUILTIN_SELF_TEST_CYCLES;
					end else begin
						nxt_seq     = cpm_pkg::SQ_RUN;
						nxt_restart = 1'b1;
					end
				end
			end
			cpm_pkg::SQ_BUILTIN_SELF_TEST: begin
				nxt_builtin_self_test_cnt = builtin_self_test_cnt_ff - 16'h0001;
				if (builtin_self_test_cnt_ff == 16'h0001) begin
					nxt_seq     = cpm_pkg::SQ_RUN;
					nxt_restart = 1'b1;
				end
			end
			cpm_pkg::SQ_RUN: begin
				if (cyc_valid && cyc_ready) begin
					nxt_bus.address_strobe_n = 1'b0;
					nxt_bus.wr_not_rd        = cyc_req.write;
					nxt_bus.byte_en_n        = ~cyc_req.byte_en;
					nxt_bus.cache_n          = ~cyc_req.cache;
					nxt_bus.lock_n           = ~cyc_req.lock;
					nxt_bus.pcd              = cyc_req.pcd;
					nxt_bus.pwt              = cyc_req.pwt;
					nxt_bus.split_cycle_flag = cyc_req.lock & cyc_req.misaligned;
				end
			end
			cpm_pkg::SQ_TRI, cpm_pkg::SQ_CHK: begin
				nxt_seq = seq_ff;
			end
			default: begin
				nxt_seq = cpm_pkg::SQ_RESET;
			end
		endcase
		if (fill_first_rdy) begin
			nxt_fill = writeback_not_writethrough ? cpm_pkg::FILL_EXCL : cpm_pkg::FILL_SHARED;
		end
		if (reset_s) begin
			nxt_seq  = cpm_pkg::SQ_RESET;
			nxt_bus  = cpm_pkg::cpm_bus_s'(`CPM_BUS_IDLE);
			nxt_pend = 1'b0;
			nxt_smm  = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			seq_ff      <= cpm_pkg::SQ_RESET;
			builtin_self_test_cnt_ff <= 16'h0000;
			reset_d_ff  <= 1'b1;
			restart_ff  <= 1'b0;
			smi_d_ff    <= 1'b1;
			pend_ff     <= 1'b0;
			smm_ff      <= 1'b0;
			bus_ff      <= cpm_pkg::cpm_bus_s'(`CPM_BUS_IDLE);
			hlda_ff     <= 1'b0;
			internal_error_n_ff     <= 1'b0;
			fill_ff     <= cpm_pkg::FILL_SHARED;
			fillv_ff    <= 1'b0;
		end else if (ce) begin
			seq_ff      <= nxt_seq;
			builtin_self_test_cnt_ff <= nxt_builtin_self_test_cnt;
			reset_d_ff  <= nxt_reset_d;
			restart_ff  <= nxt_restart;
			smi_d_ff    <= nxt_smi_d;
			pend_ff     <= nxt_pend;
			smm_ff      <= nxt_smm;
			bus_ff      <= nxt_bus;
			hlda_ff     <= nxt_hlda;
			internal_error_n_ff     <= nxt_internal_error_n;
			fill_ff     <= nxt_fill;
			fillv_ff    <= nxt_fillv;
		end
	end

	assign bus_pins          = bus_ff;
	assign bus_oe_n          = float_bus;
	assign hlda              = hlda_ff;
	assign misc_oe_n         = float_all;
	assign sys_mgmt_active_n = ~smm_ff;
	assign sys_mgmt_mode     = smm_ff;
	assign internal_error_n  = ~internal_error_n_ff;
	assign restart_pulse     = restart_ff;
	assign cache_inval_nowb  = (seq_ff == cpm_pkg::SQ_RESET);
	assign builtin_self_test = (seq_ff == cpm_pkg::SQ_BUILTIN_SELF_TEST);
	assign fill_state        = fill_ff;
	assign fill_valid        = fillv_ff;
	assign tristate_mode     = (seq_ff == cpm_pkg::SQ_TRI);
	assign checker_mode      = (seq_ff == cpm_pkg::SQ_CHK);

	// Test access port, stepped by edges of the synchronised TCK
	cpm_pkg::cpm_tap_e tap_ff, nxt_tap;
	logic [3:0]        ir_ff, nxt_ir, irsh_ff, nxt_irsh;
	logic [31:0]       dr_ff, nxt_dr;
	logic              tck_d_ff, nxt_tck_d, tdo_ff, nxt_tdo, tdoz_ff, nxt_tdoz;
	logic              tck_rise, tck_fall;

	assign tck_rise = ~tck_d_ff & tck_s;
	assign tck_fall = tck_d_ff & ~tck_s;

	always_comb begin
		nxt_tap   = tap_ff;
		nxt_ir    = ir_ff;
		nxt_irsh  = irsh_ff;
		nxt_dr    = dr_ff;
		nxt_tdo   = tdo_ff;
		nxt_tdoz  = tdoz_ff;
		nxt_tck_d = tck_s;
		if (tck_rise) begin
			case (tap_ff)
				cpm_pkg::TP_TLR:   nxt_tap = tms_s ? cpm_pkg::TP_TLR   : cpm_pkg::TP_IDLE;
				cpm_pkg::TP_IDLE:  nxt_tap = tms_s ? cpm_pkg::TP_SELDR : cpm_pkg::TP_IDLE;
				cpm_pkg::TP_SELDR: nxt_tap = tms_s ? cpm_pkg::TP_SELIR : cpm_pkg::TP_CAPDR;
				cpm_pkg::TP_CAPDR: nxt_tap = tms_s ? cpm_pkg::TP_EX1DR : cpm_pkg::TP_SHDR;
				cpm_pkg::TP_SHDR:  nxt_tap = tms_s ? cpm_pkg::TP_EX1DR : cpm_pkg::TP_SHDR;
				cpm_pkg::TP_EX1DR: nxt_tap = tms_s ? cpm_pkg::TP_UPDDR : cpm_pkg::TP_PAUDR;
				cpm_pkg::TP_PAUDR: nxt_tap = tms_s ? cpm_pkg::TP_EX2DR : cpm_pkg::TP_PAUDR;
				cpm_pkg::TP_EX2DR: nxt_tap = tms_s ? cpm_pkg::TP_UPDDR : cpm_pkg::TP_SHDR;
				cpm_pkg::TP_UPDDR: nxt_tap = tms_s ? cpm_pkg::TP_SELDR : cpm_pkg::TP_IDLE;
				cpm_pkg::TP_SELIR: nxt_tap = tms_s ? cpm_pkg::TP_TLR   : cpm_pkg::TP_CAPIR;
				cpm_pkg::TP_CAPIR: nxt_tap = tms_s ? cpm_pkg::TP_EX1IR : cpm_pkg::TP_SHIR;
				cpm_pkg::TP_SHIR:  nxt_tap = tms_s ? cpm_pkg::TP_EX1IR : cpm_pkg::TP_SHIR;
				cpm_pkg::TP_EX1IR: nxt_tap = tms_s ? cpm_pkg::TP_UPDIR : cpm_pkg::TP_PAUIR;
				cpm_pkg::TP_PAUIR: nxt_tap = tms_s ? cpm_pkg::TP_EX2IR : cpm_pkg::TP_PAUIR;
				cpm_pkg::TP_EX2IR: nxt_tap = tms_s ? cpm_pkg::TP_UPDIR : cpm_pkg::TP_SHIR;
				cpm_pkg::TP_UPDIR: nxt_tap = tms_s ? cpm_pkg::TP_SELDR : cpm_pkg::TP_IDLE;
				default:           nxt_tap = cpm_pkg::TP_TLR;
			endcase
			case (tap_ff)
				cpm_pkg::TP_TLR:   nxt_ir   = `CPM_IR_IDCODE;
				cpm_pkg::TP_CAPIR: nxt_irsh = `CPM_IR_CAPTURE;
				cpm_pkg::TP_SHIR:  nxt_irsh = {tdi_s, irsh_ff[3:1]};
				cpm_pkg::TP_UPDIR: nxt_ir   = irsh_ff;
				cpm_pkg::TP_CAPDR: nxt_dr   = (ir_ff == `CPM_IR_IDCODE) ? IDCODE_VAL
				                                                       : `CPM_DR_BYPASS_RST;
				cpm_pkg::TP_SHDR: begin
					if (ir_ff == `CPM_IR_IDCODE) begin
						nxt_dr = {tdi_s, dr_ff[31:1]};
					end else begin
						nxt_dr = {dr_ff[31:1], tdi_s};             // Bypass is one bit long
					end
				end
				default: nxt_dr = dr_ff;
			endcase
		end
		if (tck_fall) begin
			nxt_tdoz = 1'b1;
			if (tap_ff == cpm_pkg::TP_SHIR) begin
				nxt_tdo  = irsh_ff[0];
				nxt_tdoz = 1'b0;
			end else if (tap_ff == cpm_pkg::TP_SHDR) begin
				nxt_tdo  = dr_ff[0];
				nxt_tdoz = 1'b0;
			end
		end
	end

	// TRST reaches the controller with no clock needed; constants only
	always_ff @(posedge clk or negedge trst_n) begin
		if (!trst_n) begin
			tap_ff   <= cpm_pkg::TP_TLR;
			ir_ff    <= `CPM_IR_IDCODE;
			irsh_ff  <= 4'h0;
			dr_ff    <= 32'h0000_0000;
			tck_d_ff <= 1'b1;
			tdo_ff   <= 1'b0;
			tdoz_ff  <= 1'b1;
		end else if (!nrst) begin
			tap_ff   <= cpm_pkg::TP_TLR;
			ir_ff    <= `CPM_IR_IDCODE;
			irsh_ff  <= 4'h0;
			dr_ff    <= 32'h0000_0000;
			tck_d_ff <= 1'b1;
			tdo_ff   <= 1'b0;
			tdoz_ff  <= 1'b1;
		end else if (ce) begin
			tap_ff   <= nxt_tap;
			ir_ff    <= nxt_ir;
			irsh_ff  <= nxt_irsh;
			dr_ff    <= nxt_dr;
			tck_d_ff <= nxt_tck_d;
			tdo_ff   <= nxt_tdo;
			tdoz_ff  <= nxt_tdoz;
		end
	end

	// TDO keeps driving in test modes; scan must work there
	assign tdo      = tdo_ff;
	assign tdo_oe_n = tdoz_ff;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	a_strobe_with_write: assert property (cyc_valid && cyc_ready && ce |=>
		!bus_pins.address_strobe_n && bus_pins.wr_not_rd == $past(cyc_req.write))
		else $error("write/read not valid with address strobe");
	a_split_on_lock: assert property (cyc_valid && cyc_ready && ce |=>
		bus_pins.split_cycle_flag == ($past(cyc_req.lock) && $past(cyc_req.misaligned)))
		else $error("split flag wrong for cycle");
	a_reset_restarts: assert property (reset_s && ce |=> seq_ff == cpm_pkg::SQ_RESET)
		else $error("reset did not restart sequencer");
	a_reset_invalidates: assert property (reset_s && ce |=> cache_inval_nowb)
		else $error("no invalidate during reset");
	a_strap_tristate: assert property (reset_fall && !flush_s_n && ce &&
		seq_ff == cpm_pkg::SQ_RESET |=> tristate_mode) else $error("flush strap ignored");
	a_smm_entry: assert property (smm_enter && !reset_s && ce |=> sys_mgmt_mode ##0
		!sys_mgmt_active_n) else $error("latched request not entered");
	a_smm_active_held: assert property (smm_ff && !smm_exit && !reset_s && ce |=>
		!sys_mgmt_active_n) else $error("active output dropped in mode");
	a_tdi_shift_ir: assert property (tck_rise && tap_ff == cpm_pkg::TP_SHIR && ce |=>
		irsh_ff[3] == $past(tdi_s)) else $error("TDI not shifted");
	a_tdo_shift_dr: assert property (tck_fall && tap_ff == cpm_pkg::TP_SHDR && ce |=>
		!tdo_oe_n && tdo == $past(dr_ff[0])) else $error("TDO not shifted");
	a_tms_advance: assert property (tck_rise && tap_ff == cpm_pkg::TP_IDLE && tms_s &&
		ce && trst_n |=> tap_ff == cpm_pkg::TP_SELDR) else $error("TMS step wrong");
	a_trst_init: assert property (!trst_n |-> tap_ff == cpm_pkg::TP_TLR)
		else $error("test reset did not initialise");
	a_fill_policy: assert property (fill_first_rdy && ce |=> fill_valid &&
		fill_state == ($past(writeback_not_writethrough) ? cpm_pkg::FILL_EXCL
		: cpm_pkg::FILL_SHARED)) else $error("fill state wrong");
	a_test_float: assert property (tristate_mode || checker_mode |-> bus_oe_n && misc_oe_n)
		else $error("pins driven in test mode");
	a_hold_float: assert property (hlda || !bus_backoff_n |-> bus_oe_n && !cyc_ready)
		else $error("bus driven during hold or backoff");
	a_tdo_float: assert property (tck_fall && trst_n && ce && tap_ff != cpm_pkg::TP_SHDR &&
		tap_ff != cpm_pkg::TP_SHIR |=> tdo_oe_n) else $error("TDO driven outside shift");

	c_smm_entered: cover property (smm_enter ##1 sys_mgmt_mode);
	c_builtin_self_test_done:   cover property (builtin_self_test ##1 restart_pulse);
	c_dr_shift:    cover property (tap_ff == cpm_pkg::TP_SHDR && !tdo_oe_n);
	c_locked_split: cover property (bus_pins.split_cycle_flag && !bus_pins.address_strobe_n);
endmodule
`default_nettype wire

// *** bench/cpm_chipset_model.sv ***
// Chipset-side model: bus hold, backoff and line-fill answers.
// Assumes commands from the bench change at the falling edge of clk.
`timescale 1ns/1ps
`default_nettype none
module cpm_chipset_model (
	input  wire logic clk,                        // Core clock
	input  wire logic fill_req,                   // Start one line fill
	input  wire logic fill_wb,                    // Policy for that fill
	input  wire logic hold_req,                   // Ask for the bus
	input  wire logic bus_backoff_n_req,                   // Abort the bus
	output logic      hold,                       // Hold request
	output logic      bus_backoff_n,              // Backoff, low
	output logic      writeback_not_writethrough, // Valid with first ready only
	output logic      fill_first_rdy              // First ready of a fill
);
	logic [3:0] cmd_ff = 4'h0;
	initial begin
		hold = 1'h0;
		bus_backoff_n = 1'h1;
		writeback_not_writethrough = 1'h0;
		fill_first_rdy = 1'h0;
	end
	always @(posedge clk) cmd_ff <= {fill_req, fill_wb, hold_req, bus_backoff_n_req};
	// Policy line toggles outside fills so a stale sample shows
	always @(negedge clk) begin
		hold <= cmd_ff[1];
		bus_backoff_n <= ~cmd_ff[0];
		fill_first_rdy <= cmd_ff[3];
		writeback_not_writethrough <= cmd_ff[3] ? cmd_ff[2] : ~writeback_not_writethrough;
	end
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking bench for the pin-control core.
// Assumes the core, its package and the chipset model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk = 1'h0, nrst = 1'h0, ce = 1'h1, reset_pin = 1'h1, init_pin = 1'h0;
	logic flush_n = 1'h1, redundancy_check_mode_n = 1'h1, sys_mgmt_irq_n = 1'h1;
	logic tck = 1'h0, tms = 1'h1, tdi = 1'h1, trst_n = 1'h1, cyc_valid = 1'h0;
	logic instr_boundary = 1'h0, smm_exit = 1'h0, internal_fault = 1'h0;
	logic fill_req = 1'h0, fill_wb = 1'h0, hold_req = 1'h0, bus_backoff_n_req = 1'h0;
	logic hold, bus_backoff_n, writeback_not_writethrough, fill_first_rdy;
	logic cyc_ready, bus_oe_n, hlda, sys_mgmt_active_n, misc_oe_n, internal_error_n;
	logic tdo, tdo_oe_n, restart_pulse, cache_inval_nowb, builtin_self_test;
	logic sys_mgmt_mode, fill_valid, tristate_mode, checker_mode;
	cpm_pkg::cpm_cyc_s  cyc_req = '0;
	cpm_pkg::cpm_bus_s  bus_pins;
	cpm_pkg::cpm_fill_e fill_state;
	int num_errors = 0, total_checks = 0;

	always #12.5 clk = ~clk;

	// Short self test keeps the mode walk brief
	cpm_core #(.BUILTIN_SELF_TEST_CYCLES(16'h0004)) cpm_core_inst (.clk, .nrst, .ce, .reset_pin,
		.init_pin, .flush_n, .redundancy_check_mode_n, .sys_mgmt_irq_n, .hold,
		.bus_backoff_n, .writeback_not_writethrough, .tck, .tms, .tdi, .trst_n,
		.cyc_valid, .cyc_req, .instr_boundary, .smm_exit, .internal_fault,
		.fill_first_rdy, .cyc_ready, .bus_pins, .bus_oe_n, .hlda, .sys_mgmt_active_n,
		.misc_oe_n, .internal_error_n, .tdo, .tdo_oe_n, .restart_pulse,
		.cache_inval_nowb, .builtin_self_test, .sys_mgmt_mode, .fill_state,
		.fill_valid, .tristate_mode, .checker_mode);
	cpm_chipset_model cpm_chipset_model_inst (.clk, .fill_req, .fill_wb, .hold_req,
		.bus_backoff_n_req, .hold, .bus_backoff_n, .writeback_not_writethrough, .fill_first_rdy);

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			num_errors++;
			$display("MISMATCH %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wt(ref logic s);
		for (int i = 0; i < 30 && s !== 1'h1; i++) @(negedge clk);
	endtask
	task automatic end_of_test;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Straps held until the mode shows, then released
	task automatic dev_reset(input logic fl, input logic rc, input logic in);
		{flush_n, redundancy_check_mode_n, init_pin} = {fl, rc, in};
		reset_pin = 1'h1;
		cyc(4);
		chk("inval", cache_inval_nowb, 1'h1);
		reset_pin = 1'h0;
		for (int i = 0; i < 10; i++) begin
			@(negedge clk);
			if (tristate_mode | checker_mode | builtin_self_test | restart_pulse) break;
		end
		{flush_n, redundancy_check_mode_n, init_pin} = 3'h6;
	endtask
	task automatic t_modes;
		dev_reset(1'h0, 1'h1, 1'h0);
		chk("tri", tristate_mode, 1'h1);
		internal_fault = 1'h1;
		cyc(2);
		chk("tri_bus", {bus_oe_n, misc_oe_n, internal_error_n}, 3'h6);
		internal_fault = 1'h0;
		dev_reset(1'h1, 1'h0, 1'h0);
		chk("chk", {checker_mode, misc_oe_n, bus_oe_n}, 3'h7);
		dev_reset(1'h1, 1'h1, 1'h1);
		chk("builtin_self_test", builtin_self_test, 1'h1);
		wt(restart_pulse);
		chk("restart", restart_pulse, 1'h1);
		dev_reset(1'h1, 1'h1, 1'h0);
		chk("run", {restart_pulse, tristate_mode, checker_mode}, 3'h4);
		cyc(1);
		chk("inval_off", cache_inval_nowb, 1'h0);
	endtask
	task automatic t_bus(input logic w, input logic l, input logic m);
		wt(cyc_ready);
		cyc_valid = 1'h1;
		cyc_req = {w, l, m, 3'h0, 8'h0f};
		@(negedge clk);
		cyc_valid = 1'h0;
		chk("strobe", bus_pins.address_strobe_n, 1'h0);
		chk("wr", bus_pins.wr_not_rd, w);
		if (l) chk("split", bus_pins.split_cycle_flag, m);
		chk("be_lock", {bus_pins.byte_en_n, bus_pins.lock_n}, {8'hf0, ~l});
		@(negedge clk);
		chk("strobe_end", bus_pins.address_strobe_n, 1'h1);
	endtask
	task automatic t_float;
		bus_backoff_n_req = 1'h1;
		cyc(3);
		chk("bus_backoff_n", {bus_oe_n, cyc_ready}, 2'h2);
		bus_backoff_n_req = 1'h0;
		hold_req = 1'h1;
		cyc(4);
		chk("hold", {hlda, bus_oe_n}, 2'h3);
		hold_req = 1'h0;
		cyc(4);
		chk("drive", bus_oe_n, 1'h0);
	endtask
	task automatic t_fill(input logic wb);
		fill_wb = wb;
		fill_req = 1'h1;
		@(negedge clk);
		fill_req = 1'h0;
		wt(fill_valid);
		chk("fill", {fill_valid, fill_state}, {1'h1, wb});
	endtask
	task automatic t_smi;
		sys_mgmt_irq_n = 1'h0;
		cyc(5);
		sys_mgmt_irq_n = 1'h1;
		chk("no_entry", sys_mgmt_mode, 1'h0);
		instr_boundary = 1'h1;
		@(negedge clk);
		instr_boundary = 1'h0;
		wt(sys_mgmt_mode);
		cyc(4);
		chk("smm", {sys_mgmt_mode, sys_mgmt_active_n}, 2'h2);
		smm_exit = 1'h1;
		@(negedge clk);
		smm_exit = 1'h0;
		cyc(2);
		chk("smm_off", sys_mgmt_active_n, 1'h1);
	endtask
	// Test clock kept slow: six core clocks per phase
	task automatic ts(input logic m, input logic d, output logic o);
		{tms, tdi} = {m, d};
		tck = 1'h1;
		cyc(6);
		tck = 1'h0;
		cyc(6);
		o = tdo;
	endtask
	task automatic t_tap;
		logic o;
		logic [3:0] ir;
		cyc(4);
		ts(1'h0, 1'h0, o);
		ts(1'h1, 1'h0, o);
		ts(1'h1, 1'h0, o);
		ts(1'h0, 1'h0, o);
		ts(1'h0, 1'h1, ir[0]);
		chk("shir_oe", tdo_oe_n, 1'h0);
		for (int i = 1; i < 4; i++) ts(1'h0, 1'h1, ir[i]);
		chk("ir_out", ir, 4'h1);
		ts(1'h1, 1'h1, o);
		chk("ex_oe", tdo_oe_n, 1'h1);
		ts(1'h1, 1'h0, o);
		ts(1'h0, 1'h0, o);
		ts(1'h1, 1'h0, o);
		ts(1'h0, 1'h0, o);
		ts(1'h0, 1'h0, o);
		chk("byp_cap", o, 1'h0);
		ts(1'h0, 1'h1, o);
		chk("byp_in", o, 1'h1);
		chk("shdr_oe", tdo_oe_n, 1'h0);
		// Test reset from a shift state, seen before any clock edge
		trst_n = 1'h0;
		#1;
		chk("trst", tdo_oe_n, 1'h1);
		cyc(1);
		trst_n = 1'h1;
	endtask

	initial begin
		#100_000;
		num_errors++;
		end_of_test();
	end
	initial begin
		cyc(6);
		nrst = 1'h1;
		t_modes();
		// Unlocked cycle last: a held lock would refuse the bus hold
		t_bus(1'h1, 1'h1, 1'h1);
		t_bus(1'h0, 1'h0, 1'h0);
		t_float();
		t_fill(1'h1);
		t_fill(1'h0);
		t_smi();
		t_tap();
		end_of_test();
	end
endmodule
`default_nettype wire
